//--- verilog/spsc_defs.svh
`ifndef SPSC_DEFS_SVH
`define SPSC_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define SPSC_ADDR_STAT      12'h000
`define SPSC_ADDR_DATA      12'h004
`define SPSC_ADDR_IRQ_STAT  12'h008
`define SPSC_ADDR_IRQ_MASK  12'h00c
`define SPSC_ADDR_CFG       12'h010

// ----------------------------------------------------------------------
// Status/control field positions
// ----------------------------------------------------------------------
`define SPSC_BIT_PORT_ON    15
`define SPSC_BIT_HALT_IDLE  13
`define SPSC_BIT_CNT_HI     10
`define SPSC_BIT_CNT_LO     8
`define SPSC_BIT_SH_EMPTY   7
`define SPSC_BIT_RX_OVF     6
`define SPSC_BIT_RX_EMPTY   5
`define SPSC_BIT_SEL_HI     4
`define SPSC_BIT_SEL_LO     2
`define SPSC_BIT_RX_FULL    1
`define SPSC_BIT_TX_FULL    0

// Config register bits
`define SPSC_BIT_ENH        0
`define SPSC_BIT_MASTER     1

// Event bits in interrupt status and mask
`define SPSC_EV_BUF         0
`define SPSC_EV_OVF         1

// ----------------------------------------------------------------------
// Buffer depths and word size
// ----------------------------------------------------------------------
`define SPSC_DEPTH_ENH      3'd4
`define SPSC_DEPTH_STD      3'd1
`define SPSC_LAST_BIT       4'd7

// ----------------------------------------------------------------------
// Interrupt mode codes
// ----------------------------------------------------------------------
`define SPSC_SEL_TX_FULL    3'h7
`define SPSC_SEL_TX_EMPTY   3'h6
`define SPSC_SEL_TX_DONE    3'h5
`define SPSC_SEL_TX_SPOT    3'h4
`define SPSC_SEL_RX_FULL    3'h3
`define SPSC_SEL_RX_3Q      3'h2
`define SPSC_SEL_RX_AVAIL   3'h1
`define SPSC_SEL_RX_DRAIN   3'h0
`define SPSC_RX_3Q_LEVEL    3'd3

`endif

//--- verilog/spsc_pkg.sv
package spsc_pkg;

   // Whole state of the port, registered as one word
   typedef struct packed {
      logic [2:0]       sclk_p;
      logic [1:0]       sdi_p;
      logic [1:0]       ssn_p;
      logic             port_on;
      logic             halt_in_idle;
      logic [2:0]       irq_mode_select;
      logic             rx_overflow_flag;
      logic             enh;
      logic             master;
      logic [3:0][7:0]  txm;
      logic [3:0][7:0]  rxm;
      logic [1:0]       tx_rd;
      logic [1:0]       rx_rd;
      logic [2:0]       tx_cnt;
      logic [2:0]       rx_cnt;
      logic [7:0]       tsh;
      logic [7:0]       rsh;
      logic [3:0]       bitcnt;
      logic             sh_full;
      logic             cond_prev;
      logic [1:0]       ev_stat;
      logic [1:0]       ev_mask;
      logic             irq;
      logic             sdo;
      logic             sdo_oe;
      logic             pins_owned;
      logic             pready;
      logic             pslverr;
      logic [31:0]      prdata;
   } spsc_state_s;

endpackage

//--- verilog/spsc_port.sv
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "spsc_defs.svh"
// Summary of operation
// - Port enable bit switches module on and hands link pins to it.
// - With halt-in-idle set, the port stops while CPU idles.
// - Enhanced master: element count shows pending transmit transfers.
// - Enhanced slave: element count shows received words not yet read.
// - Shifter-empty reads one while shift register holds no data.
// - Word arriving into full receive buffer is dropped; overflow flag sticks.
// - Receive-empty flag reads one when receive FIFO holds nothing.
// - Modes 111/110: interrupt on transmit full, or transmit emptied.
// - Modes 101/100: interrupt on transmit complete, or one spot freed.
// - Modes 011/010: interrupt on receive full, or three quarters full (010 fires in enhanced mode only).
// - Modes 001/000: interrupt on receive data present, or drained by read.
module spsc_port
   import spsc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        cpu_idle,
   input  wire logic        sclk_in,
   input  wire logic        sdi_in,
   input  wire logic        ss_n_in,
   output logic             sdo_out,
   output logic             sdo_oe,
   output logic             pins_owned,
   output logic             irq
);

   spsc_state_s q;
   spsc_state_s next_q;

   logic        run;
   logic        active;
   logic        rise;
   logic        fall;
   logic [2:0]  depth;
   logic        acc;
   logic        prep;
   logic        wr_stat;
   logic        tx_push;
   logic        tx_pop;
   logic        rx_pop;
   logic        rx_done;
   logic        rx_push;
   logic        cond;
   logic [7:0]  rx_word;
   logic [7:0]  tx_word;
   logic [2:0]  rx_after_pop;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic is_full(input logic [2:0] cnt, input logic [2:0] dep);
      is_full = (cnt == dep);
   endfunction

   function automatic logic buf_cond(input spsc_state_s s, input logic [2:0] dep);
      buf_cond = 1'b0;
      case (s.irq_mode_select)
         `SPSC_SEL_TX_FULL:  buf_cond = is_full(s.tx_cnt, dep);
         `SPSC_SEL_TX_EMPTY: buf_cond = (s.tx_cnt == 3'd0) && s.sh_full;
         `SPSC_SEL_TX_DONE:  buf_cond = (s.tx_cnt == 3'd0) && !s.sh_full;
         `SPSC_SEL_TX_SPOT:  buf_cond = !is_full(s.tx_cnt, dep);
         `SPSC_SEL_RX_FULL:  buf_cond = is_full(s.rx_cnt, dep);
         `SPSC_SEL_RX_3Q:    buf_cond = (s.rx_cnt >= `SPSC_RX_3Q_LEVEL);
         `SPSC_SEL_RX_AVAIL: buf_cond = (s.rx_cnt != 3'd0);
         default:            buf_cond = (s.rx_cnt == 3'd0);
      endcase
   endfunction

   function automatic logic [31:0] stat_word(input spsc_state_s s, input logic [2:0] dep);
      stat_word = 32'h0;
      stat_word[`SPSC_BIT_PORT_ON] = s.port_on;
      stat_word[`SPSC_BIT_HALT_IDLE] = s.halt_in_idle;
      stat_word[`SPSC_BIT_CNT_HI:`SPSC_BIT_CNT_LO] = s.master ? s.tx_cnt : s.rx_cnt;
      stat_word[`SPSC_BIT_SH_EMPTY] = !s.sh_full;
      stat_word[`SPSC_BIT_RX_OVF] = s.rx_overflow_flag;
      stat_word[`SPSC_BIT_RX_EMPTY] = (s.rx_cnt == 3'd0);
      stat_word[`SPSC_BIT_SEL_HI:`SPSC_BIT_SEL_LO] = s.irq_mode_select;
      stat_word[`SPSC_BIT_RX_FULL] = is_full(s.rx_cnt, dep);
      stat_word[`SPSC_BIT_TX_FULL] = is_full(s.tx_cnt, dep);
   endfunction

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb
   begin
      next_q = q;
      depth = q.enh ? `SPSC_DEPTH_ENH : `SPSC_DEPTH_STD;

      // Pin synchronisers; stage 0 only feeds stage 1
      next_q.sclk_p = {q.sclk_p[1:0], sclk_in};
      next_q.sdi_p = {q.sdi_p[0], sdi_in};
      next_q.ssn_p = {q.ssn_p[0], ss_n_in};
      rise = q.sclk_p[1] && !q.sclk_p[2];
      fall = !q.sclk_p[1] && q.sclk_p[2];

      run = q.port_on && !(q.halt_in_idle && cpu_idle);
      active = run && !q.ssn_p[1];

      // Bus: one wait state, effect at the completing edge
      acc = psel && penable && q.pready;
      prep = psel && penable && !q.pready;
      wr_stat = acc && pwrite && (paddr == `SPSC_ADDR_STAT);
      tx_push = acc && pwrite && (paddr == `SPSC_ADDR_DATA) && q.port_on
                && !is_full(q.tx_cnt, depth);
      rx_pop = acc && !pwrite && (paddr == `SPSC_ADDR_DATA) && (q.rx_cnt != 3'd0);

      // Shifter
      tx_pop = active && (q.bitcnt == 4'd0) && !q.sh_full && (q.tx_cnt != 3'd0);
      tx_word = q.txm[q.tx_rd];
      rx_done = active && rise && (q.bitcnt == `SPSC_LAST_BIT);
      rx_word = {q.rsh[6:0], q.sdi_p[1]};
      rx_after_pop = q.rx_cnt - {2'b00, rx_pop};
      rx_push = rx_done && !is_full(rx_after_pop, depth);

      if (!active)
      begin
         // A word loaded but not yet started waits for the next frame
         next_q.bitcnt = 4'd0;
         next_q.sh_full = q.sh_full && (q.bitcnt == 4'd0);
      end
      else if (tx_pop)
      begin
         next_q.sdo = tx_word[7];
         next_q.tsh = {tx_word[6:0], 1'b0};
         next_q.sh_full = 1'b1;
      end
      else if (rise)
      begin
         next_q.rsh = rx_word;
         next_q.sh_full = (q.bitcnt != `SPSC_LAST_BIT);
         next_q.bitcnt = (q.bitcnt == `SPSC_LAST_BIT) ? 4'd0 : q.bitcnt + 4'd1;
      end
      else if (fall && q.bitcnt != 4'd0)
      begin
         next_q.sdo = q.tsh[7];
         next_q.tsh = {q.tsh[6:0], 1'b0};
      end

      // Transmit FIFO
      if (tx_push)
         next_q.txm[2'(q.tx_rd + q.tx_cnt[1:0])] = pwdata[7:0];
      if (tx_pop)
         next_q.tx_rd = q.tx_rd + 2'd1;
      next_q.tx_cnt = q.tx_cnt + {2'b00, tx_push} - {2'b00, tx_pop};

      // Receive FIFO; a word with no room is dropped
      if (rx_push)
         next_q.rxm[2'(q.rx_rd + q.rx_cnt[1:0])] = rx_word;
      if (rx_pop)
         next_q.rx_rd = q.rx_rd + 2'd1;
      next_q.rx_cnt = rx_after_pop + {2'b00, rx_push};

      // Control writes; overflow clears only by writing zero
      if (wr_stat)
      begin
         next_q.port_on = pwdata[`SPSC_BIT_PORT_ON];
         next_q.halt_in_idle = pwdata[`SPSC_BIT_HALT_IDLE];
         next_q.irq_mode_select = pwdata[`SPSC_BIT_SEL_HI:`SPSC_BIT_SEL_LO];
         if (!pwdata[`SPSC_BIT_RX_OVF])
            next_q.rx_overflow_flag = 1'b0;
      end
      if (rx_done && !rx_push)
         next_q.rx_overflow_flag = 1'b1;
      if (acc && pwrite && paddr == `SPSC_ADDR_CFG)
      begin
         next_q.enh = pwdata[`SPSC_BIT_ENH];
         next_q.master = pwdata[`SPSC_BIT_MASTER];
      end
      if (acc && pwrite && paddr == `SPSC_ADDR_IRQ_MASK)
         next_q.ev_mask = pwdata[1:0];

      // Switching off empties both buffers and the shifter
      if (!q.port_on)
      begin
         next_q.tx_cnt = 3'd0;
         next_q.rx_cnt = 3'd0;
         next_q.tx_rd = 2'd0;
         next_q.rx_rd = 2'd0;
         next_q.sdo = 1'b0;
         next_q.sh_full = 1'b0;
      end

      // Interrupt events, set beats a same-cycle clear
      cond = buf_cond(q, depth);
      next_q.cond_prev = cond;
      if (acc && pwrite && paddr == `SPSC_ADDR_IRQ_STAT)
         next_q.ev_stat = q.ev_stat & ~pwdata[1:0];
      if (cond && !q.cond_prev)
         next_q.ev_stat[`SPSC_EV_BUF] = 1'b1;
      if (rx_done && !rx_push)
         next_q.ev_stat[`SPSC_EV_OVF] = 1'b1;
      next_q.irq = |(next_q.ev_stat & next_q.ev_mask);

      next_q.sdo_oe = active;
      next_q.pins_owned = q.port_on;

      // Bus answer
      next_q.pready = prep;
      next_q.pslverr = 1'b0;
      next_q.prdata = 32'h0;
      if (prep)
      begin
         if (paddr == `SPSC_ADDR_STAT)
            next_q.prdata = stat_word(q, depth);
         else if (paddr == `SPSC_ADDR_DATA)
            next_q.prdata = {24'h0, q.rxm[q.rx_rd]};
         else if (paddr == `SPSC_ADDR_IRQ_STAT)
            next_q.prdata = {30'h0, q.ev_stat};
         else if (paddr == `SPSC_ADDR_IRQ_MASK)
            next_q.prdata = {30'h0, q.ev_mask};
         else if (paddr == `SPSC_ADDR_CFG)
            next_q.prdata = {30'h0, q.master, q.enh};
         else
            next_q.pslverr = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         q <= '0;
      else
         q <= next_q;
   end

   assign pready = q.pready;
   assign prdata = q.prdata;
   assign pslverr = q.pslverr;
   assign sdo_out = q.sdo;
   assign sdo_oe = q.sdo_oe;
   assign pins_owned = q.pins_owned;
   assign irq = q.irq;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_port_off_pins: assert property (
      !q.port_on |=> !q.sdo_oe && !q.pins_owned ##1 q.tx_cnt == 3'd0 || q.port_on)
      else $error("port off but pins still held");

   a_idle_halt_stop: assert property (
      q.port_on && q.halt_in_idle && cpu_idle |=> !q.sdo_oe)
      else $error("port kept running in idle");

   a_count_master_tx: assert property (
      prep && paddr == `SPSC_ADDR_STAT && q.master
      |=> q.prdata[10:8] == $past(q.tx_cnt))
      else $error("master count not pending transfers");

   a_count_slave_rx: assert property (
      prep && paddr == `SPSC_ADDR_STAT && !q.master
      |=> q.prdata[10:8] == $past(q.rx_cnt))
      else $error("slave count not unread words");

   a_shifter_empty_flag: assert property (
      prep && paddr == `SPSC_ADDR_STAT |=> q.prdata[7] == !$past(q.sh_full))
      else $error("shifter empty flag wrong");

   a_overflow_drop_set: assert property (
      rx_done && is_full(q.rx_cnt, depth) && !rx_pop
      |=> q.rx_overflow_flag && q.rx_cnt == $past(q.rx_cnt))
      else $error("overflow word not dropped or flag not set");

   a_overflow_sticky: assert property (
      q.rx_overflow_flag && !wr_stat |=> q.rx_overflow_flag)
      else $error("overflow flag cleared itself");

   a_rx_empty_flag: assert property (
      prep && paddr == `SPSC_ADDR_STAT |=> q.prdata[5] == ($past(q.rx_cnt) == 3'd0))
      else $error("receive empty flag wrong");

   a_mode_tx_full: assert property (
      q.irq_mode_select == `SPSC_SEL_TX_FULL && q.enh && q.tx_cnt == 3'd4
      && !q.cond_prev |=> q.ev_stat[0])
      else $error("transmit full event missed");

   a_mode_tx_done: assert property (
      q.irq_mode_select == `SPSC_SEL_TX_DONE && q.tx_cnt == 3'd0 && !q.sh_full
      && !q.cond_prev |=> q.ev_stat[0])
      else $error("transmit done event missed");

   a_mode_rx_3q: assert property (
      q.irq_mode_select == `SPSC_SEL_RX_3Q && q.rx_cnt >= 3'd3
      && !q.cond_prev |=> q.ev_stat[0])
      else $error("three quarter event missed");

   a_mode_rx_drain: assert property (
      q.irq_mode_select == `SPSC_SEL_RX_DRAIN && q.rx_cnt == 3'd1 && rx_pop
      && !rx_push |=> ##1 q.ev_stat[0])
      else $error("drain event missed");

   a_mode_tx_empty: assert property (
      q.irq_mode_select == `SPSC_SEL_TX_EMPTY && q.tx_cnt == 3'd0 && q.sh_full
      && !q.cond_prev |=> q.ev_stat[0])
      else $error("transmit empty event missed");

   a_mode_tx_spot: assert property (
      q.irq_mode_select == `SPSC_SEL_TX_SPOT && tx_pop && is_full(q.tx_cnt, depth)
      && !wr_stat |=> ##1 q.ev_stat[0])
      else $error("transmit spot event missed");

   a_mode_rx_full: assert property (
      q.irq_mode_select == `SPSC_SEL_RX_FULL && is_full(q.rx_cnt, depth)
      && !q.cond_prev |=> q.ev_stat[0])
      else $error("receive full event missed");

   a_mode_rx_avail: assert property (
      q.irq_mode_select == `SPSC_SEL_RX_AVAIL && q.rx_cnt != 3'd0
      && !q.cond_prev |=> q.ev_stat[0])
      else $error("receive data event missed");

   a_rx_push_count: assert property (
      rx_push && !rx_pop |=> q.rx_cnt == $past(q.rx_cnt) + 3'd1)
      else $error("received word not counted");

   a_event_edge_irq: assert property (
      cond && !q.cond_prev && q.ev_mask[0] |=> q.ev_stat[0] ##1 q.irq)
      else $error("edge did not raise interrupt");

   a_apb_one_wait: assert property (
      prep |=> q.pready ##1 !q.pready)
      else $error("bus answer timing wrong");

   c_word_received: cover property (rx_push);
   c_overflow: cover property (rx_done && !rx_push);
   c_irq_raised: cover property (!q.irq ##1 q.irq);
   c_tx_loaded: cover property (tx_pop ##[1:100] rx_done);

endmodule // spsc_port

//--- tb/spsc_link_master.sv
`timescale 1ns/1ps
module spsc_link_master (
   output logic      sclk,
   output logic      sdi,
   output logic      ss_n,
   input  wire logic sdo,
   input  wire logic sdo_oe
);
   // ----------------------------------------
   // Idle link: clock still, select high
   // ----------------------------------------
   initial
   begin
      sclk = 1'b0;
      sdi  = 1'b0;
      ss_n = 1'b1;
   end

   // ----------------------------------------
   // One frame: change on fall, sample on rise
   // ----------------------------------------
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      #7 ss_n = 1'b0;
      #40;
      for (int i = 7; i >= 0; i--)
      begin
         sdi = tx[i];
         #16 sclk = 1'b1;
         // Undriven line must not pass for data
         rx[i] = sdo_oe ? sdo : 1'bx;
         #16 sclk = 1'b0;
      end
      // Released line: no pull, so show the inverse
      #8 sdi = ~sdi;
      ss_n = 1'b1;
      #40;
   endtask
endmodule // spsc_link_master

//--- tb/serial_port_status_control_tb.sv
`timescale 1ns/1ps
`include "spsc_defs.svh"
module serial_port_status_control_tb;
   localparam logic [11:0] A_ST = `SPSC_ADDR_STAT;
   localparam logic [11:0] A_DT = `SPSC_ADDR_DATA;
   localparam logic [11:0] A_IS = `SPSC_ADDR_IRQ_STAT;
   localparam logic [11:0] A_IM = `SPSC_ADDR_IRQ_MASK;
   localparam logic [11:0] A_CF = `SPSC_ADDR_CFG;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic        cpu_idle, sclk, sdi, ss_n, sdo_out, sdo_oe, pins_owned, irq, err;
   logic [7:0]  rx;
   int          n_fail = 0;
   int          compares = 0;
   int          cyc = 0;

   spsc_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .cpu_idle(cpu_idle), .sclk_in(sclk),
      .sdi_in(sdi), .ss_n_in(ss_n), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
      .pins_owned(pins_owned), .irq(irq));
   spsc_link_master LINK (.sclk(sclk), .sdi(sdi), .ss_n(ss_n), .sdo(sdo_out),
      .sdo_oe(sdo_oe));

   initial pclk = 1'b0;
   always #2 pclk = ~pclk;

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic complete_run;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      r   = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic arm(input logic [31:0] st);
      apb(1'b1, A_ST, st);
      apb(1'b1, A_IS, 32'h3);
      wt(3);
      chk({31'h0, irq}, 32'h0);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      apb(1'b0, A_ST, 32'h0);
      chk(r, 32'h0000_00a0);
      apb(1'b0, 12'hffc, 32'h0);
      chk({r[30:0], err}, 32'h1);
      apb(1'b1, A_CF, 32'h1);
      apb(1'b1, A_ST, 32'h8000);
      wt(2);
      chk({31'h0, pins_owned}, 32'h1);
      apb(1'b0, A_ST, 32'h0);
      chk(r, 32'h80a0);
   endtask

   task automatic t_rx;
      LINK.xfer(8'ha5, rx);
      chk({24'h0, rx}, 32'h0);
      apb(1'b0, A_ST, 32'h0);
      chk(r, 32'h8180);
      apb(1'b0, A_DT, 32'h0);
      chk(r, 32'ha5);
      apb(1'b0, A_ST, 32'h0);
      chk(r, 32'h80a0);
   endtask

   task automatic t_tx;
      apb(1'b1, A_CF, 32'h3);
      apb(1'b1, A_DT, 32'h3c);
      apb(1'b1, A_DT, 32'h5a);
      apb(1'b0, A_ST, 32'h0);
      chk(r, 32'h82a0);
      LINK.xfer(8'h11, rx);
      chk({24'h0, rx}, 32'h3c);
      apb(1'b0, A_ST, 32'h0);
      chk(r, 32'h8000);
      LINK.xfer(8'h22, rx);
      chk({24'h0, rx}, 32'h5a);
      apb(1'b0, A_ST, 32'h0);
      chk(r, 32'h8080);
      apb(1'b0, A_DT, 32'h0);
      chk(r, 32'h11);
      apb(1'b0, A_DT, 32'h0);
      chk(r, 32'h22);
   endtask

   task automatic t_ovf;
      apb(1'b1, A_CF, 32'h0);
      LINK.xfer(8'h66, rx);
      LINK.xfer(8'h77, rx);
      apb(1'b0, A_IS, 32'h0);
      chk(r & 32'h2, 32'h2);
      apb(1'b0, A_DT, 32'h0);
      chk(r, 32'h66);
      apb(1'b0, A_ST, 32'h0);
      chk(r & 32'h42, 32'h40);
      apb(1'b1, A_ST, 32'h8000);
      apb(1'b0, A_ST, 32'h0);
      chk(r & 32'h40, 32'h0);
   endtask

   task automatic t_idle;
      apb(1'b1, A_CF, 32'h1);
      apb(1'b1, A_ST, 32'ha000);
      cpu_idle <= 1'b1;
      LINK.xfer(8'h5c, rx);
      chk({24'h0, rx}, 32'h0000_00xx);
      apb(1'b0, A_ST, 32'h0);
      chk(r & 32'h20, 32'h20);
      apb(1'b1, A_ST, 32'h8000);
      LINK.xfer(8'h5c, rx);
      apb(1'b0, A_DT, 32'h0);
      chk(r, 32'h5c);
      cpu_idle <= 1'b0;
   endtask

   task automatic t_irq;
      apb(1'b1, A_IM, 32'h1);
      apb(1'b1, A_ST, 32'h8004);
      apb(1'b1, A_IS, 32'h3);
      wt(3);
      chk({31'h0, irq}, 32'h0);
      LINK.xfer(8'h33, rx);
      chk({31'h0, irq}, 32'h1);
      // Level still true: no second request after clear
      apb(1'b1, A_IS, 32'h1);
      wt(3);
      chk({31'h0, irq}, 32'h0);
      apb(1'b0, A_DT, 32'h0);
      apb(1'b1, A_ST, 32'h801c);
      apb(1'b1, A_IS, 32'h1);
      repeat (3) apb(1'b1, A_DT, 32'h1);
      wt(3);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, A_DT, 32'h1);
      wt(3);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, A_IM, 32'h0);
      wt(3);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, A_ST, 32'h0);
      wt(3);
      chk({31'h0, pins_owned}, 32'h0);
   endtask

   task automatic t_rx_modes;
      apb(1'b1, A_IM, 32'h1);
      arm(32'h8008);
      for (int i = 1; i <= 3; i++)
      begin
         LINK.xfer(8'(i), rx);
         chk({31'h0, irq}, {31'h0, i == 3});
      end
      arm(32'h800c);
      LINK.xfer(8'h04, rx);
      chk({31'h0, irq}, 32'h1);
      apb(1'b0, A_ST, 32'h0);
      chk(r, 32'h848e);
      arm(32'h8000);
      for (int i = 1; i <= 4; i++)
      begin
         apb(1'b0, A_DT, 32'h0);
         wt(3);
         chk(r, i);
         chk({31'h0, irq}, {31'h0, i == 4});
      end
   endtask

   task automatic t_tx_modes;
      apb(1'b1, A_CF, 32'h3);
      arm(32'h8010);
      for (int i = 1; i <= 4; i++)
      begin
         apb(1'b1, A_DT, 32'h80 + i);
      end
      wt(3);
      chk({31'h0, irq}, 32'h0);
      LINK.xfer(8'h00, rx);
      chk({24'h0, rx}, 32'h81);
      chk({31'h0, irq}, 32'h1);
      arm(32'h8018);
      LINK.xfer(8'h00, rx);
      chk({24'h0, rx}, 32'h82);
      chk({31'h0, irq}, 32'h0);
      LINK.xfer(8'h00, rx);
      chk({24'h0, rx}, 32'h83);
      chk({31'h0, irq}, 32'h1);
      apb(1'b0, A_ST, 32'h0);
      chk(r, 32'h8018);
      arm(32'h8014);
      LINK.xfer(8'h00, rx);
      chk({24'h0, rx}, 32'h84);
      chk({31'h0, irq}, 32'h1);
      apb(1'b0, A_ST, 32'h0);
      chk(r, 32'h8096);
   endtask

   // ----------------------------------------
   // Main sequence and hang guard
   // ----------------------------------------
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_fail++;
         complete_run;
      end
   end

   initial
   begin
      presetn  = 1'b0;
      psel     = 1'b0;
      penable  = 1'b0;
      pwrite   = 1'b0;
      paddr    = 12'h0;
      pwdata   = 32'h0;
      cpu_idle = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_rx;
      t_tx;
      t_ovf;
      t_idle;
      t_irq;
      t_rx_modes;
      t_tx_modes;
      complete_run;
   end
endmodule // serial_port_status_control_tb
